// >>> design/lars_params.svh
// Constants for the linear array readout sequencer.
`ifndef LARS_PARAMS_SVH
`define LARS_PARAMS_SVH
`define LARS_NSEC 5
`define LARS_NPIX 128
`define LARS_PIXW 8
`define LARS_END_EDGE 129
`define LARS_FIFO_DEPTH 16
`define LARS_IDX_W 7
`endif

// >>> design/lars_pkg.sv
// Types shared by the linear array readout sequencer.
`include "lars_params.svh"
package lars_pkg;
	typedef struct packed {
		logic [2:0] section;
		logic [`LARS_IDX_W-1:0] index;
		logic [`LARS_PIXW-1:0] level;
	} lars_pix_s;
	typedef enum logic {LARS_IDLE, LARS_SCAN} lars_state_e;
endpackage : lars_pkg

// >>> design/lars_seq.sv
// Five-section linear array readout sequencer with an output FIFO.
`timescale 1ns/10ps
`default_nettype none
`include "lars_params.svh"

// ==========================================================================
// Synchronous FIFO
module lars_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = `LARS_FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr];

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : lars_fifo

// ==========================================================================
// Readout sequencer top
module lars_seq
	import lars_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [`LARS_NSEC-1:0] scan_start,
	input wire logic serial_mode,
	input wire logic [`LARS_NSEC*`LARS_PIXW-1:0] pixel_level,
	output logic [`LARS_NSEC-1:0] scan_done,
	output logic last_section_scan_done,
	output logic [`LARS_NSEC*`LARS_PIXW-1:0] pixel_out,
	output logic [`LARS_NSEC-1:0] pixel_out_oe,
	output logic [`LARS_NSEC*`LARS_NPIX-1:0] integ_reset,
	output logic [`LARS_NSEC-1:0] scan_active,
	output logic [$bits(lars_pix_s)-1:0] stream_data,
	output logic stream_valid,
	input wire logic stream_ready,
	output logic overrun
);
	localparam int PW = `LARS_PIXW;
	localparam int NP = `LARS_NPIX;
	lars_pix_s sec_word [`LARS_NSEC];
	logic [`LARS_NSEC-1:0] sec_valid;
	logic [`LARS_NSEC-1:0] eff_start;
	lars_pix_s pick;
	logic pick_valid;
	logic fifo_ready;

	// Serial mode ties each done to the next start; sec 1 always external.
	always_comb begin
		eff_start = scan_start;
		if (serial_mode) begin
			eff_start[`LARS_NSEC-1:1] = scan_done[`LARS_NSEC-2:0];
		end
	end
	assign last_section_scan_done = scan_done[`LARS_NSEC-1];

	// One generate branch per section, all on the shared clock.
	for (genvar s = 0; s < `LARS_NSEC; s++) begin : g_sec
		logic [NP-1:0] token;
		logic done_q;
		logic [PW-1:0] level_q;
		logic [`LARS_IDX_W-1:0] idx;
		logic [NP-1:0] rst_q;
		lars_state_e state;

		// A new start loads the token only when idle: restarting mid-scan
		// would present two pixels at once.
		always_ff @(posedge clock or posedge rst) begin
			if (rst) begin
				token <= '0;
				state <= LARS_IDLE;
			end else begin
				case (state)
					LARS_IDLE: begin
						if (eff_start[s]) begin
							token <= {{(NP-1){1'b0}}, 1'b1};
							state <= LARS_SCAN;
						end
					end
					LARS_SCAN: begin
						token <= {token[NP-2:0], 1'b0};
						if (token[NP-1]) begin
							state <= LARS_IDLE;
						end
					end
					default: begin
						state <= LARS_IDLE;
					end
				endcase
			end
		end

		always_ff @(posedge clock or posedge rst) begin
			if (rst) begin
				done_q <= 1'b0;
			end else begin
				done_q <= (state == LARS_SCAN) && token[NP-1];
			end
		end

		// Sample the selected pixel level so data comes from flops.
		always_ff @(posedge clock or posedge rst) begin
			if (rst) begin
				level_q <= '0;
				idx <= '0;
			end else if (state == LARS_SCAN) begin
				level_q <= pixel_level[s*PW +: PW];
				idx <= idx + 1'b1;
			end else begin
				idx <= '0;
			end
		end

		// The pixel read on one edge has its integrator reset on that same edge.
		always_ff @(posedge clock or posedge rst) begin
			if (rst) begin
				rst_q <= '0;
			end else begin
				rst_q <= (state == LARS_SCAN) ? token : '0;
			end
		end

		assign scan_done[s] = done_q;
		assign scan_active[s] = (state == LARS_SCAN);
		assign integ_reset[s*NP +: NP] = rst_q;
		assign pixel_out[s*PW +: PW] = level_q;
		assign pixel_out_oe[s] = sec_valid[s];
		assign sec_word[s] = '{section: 3'(s), index: idx - 1'b1,
			level: level_q};

		always_ff @(posedge clock or posedge rst) begin
			if (rst) begin
				sec_valid[s] <= 1'b0;
			end else begin
				sec_valid[s] <= (state == LARS_SCAN);
			end
		end
	end

	// Lowest-numbered presenting section feeds the stream; in serial mode
	// only an external sec 1 restart mid-chain can present alongside another.
	always_comb begin
		pick = sec_word[0];
		pick_valid = 1'b0;
		for (int i = `LARS_NSEC-1; i >= 0; i--) begin
			if (sec_valid[i]) begin
				pick = sec_word[i];
				pick_valid = 1'b1;
			end
		end
	end

	// The scan cannot stall, so a full FIFO drops the pixel and flags it.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			overrun <= 1'b0;
		end else if (pick_valid && !fifo_ready) begin
			overrun <= 1'b1;
		end
	end

	lars_fifo #(
		.WIDTH($bits(lars_pix_s)),
		.DEPTH(`LARS_FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.rst(rst),
		.in_data(pick),
		.in_valid(pick_valid),
		.in_ready(fifo_ready),
		.out_data(stream_data),
		.out_valid(stream_valid),
		.out_ready(stream_ready)
	);
endmodule : lars_seq
`default_nettype wire

// >>> test/lars_seq_asserts.sv
// Port checker for the readout sequencer.
`timescale 1ns/10ps
`default_nettype none
module lars_seq_asserts (
	input wire logic clock,
	input wire logic rst,
	input wire logic serial_mode,
	input wire logic [4:0] scan_start,
	input wire logic [4:0] scan_done,
	input wire logic last_section_scan_done,
	input wire logic [4:0] pixel_out_oe,
	input wire logic [639:0] integ_reset,
	input wire logic [4:0] scan_active
);
	// ==========
	// Section one timing and the last-section done output
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	last_done_a: assert property (last_section_scan_done == scan_done[4])
		else $error("last done differs");
	done_time_a: assert property ($rose(scan_active[0]) |-> ##128 scan_done[0])
		else $error("done late or early");
	done_pulse_a: assert property (scan_done[0] |=> !scan_done[0])
		else $error("done too long");
	oe_start_a: assert property ($rose(scan_active[0]) |=> pixel_out_oe[0])
		else $error("oe missing");
	oe_hold_a: assert property ($rose(pixel_out_oe[0]) |-> pixel_out_oe[0][*8])
		else $error("oe dropped");
	integ_seq_a: assert property ($rose(pixel_out_oe[0]) |->
		integ_reset[0] ##1 integ_reset[1])
		else $error("reset order wrong");
	start_take_a: assert property (scan_start[0] && !scan_active[0] &&
		!serial_mode |=> scan_active[0])
		else $error("start lost");
	serial_chain_a: assert property (serial_mode && scan_done[0] |=>
		scan_active[1])
		else $error("chain broken");
	oe_idle_a: assert property (!scan_active[0] && !$past(scan_active[0])
		|-> !pixel_out_oe[0])
		else $error("oe while idle");
endmodule : lars_seq_asserts
bind lars_seq lars_seq_asserts chk (.clock(clock), .rst(rst),
	.serial_mode(serial_mode), .scan_start(scan_start),
	.scan_done(scan_done), .last_section_scan_done(last_section_scan_done),
	.pixel_out_oe(pixel_out_oe), .integ_reset(integ_reset),
	.scan_active(scan_active));
`default_nettype wire

// >>> test/lars_sink.sv
// Stream sink model that can stall on command.
`timescale 1ns/10ps
`default_nettype none
module lars_sink (
	input wire logic clock,
	input wire logic rst,
	input wire logic stall,
	input wire logic [17:0] stream_data,
	input wire logic stream_valid,
	output logic stream_ready,
	output logic [17:0] last_word
);
	assign stream_ready = !stall;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) last_word <= 18'h00000;
		else if (stream_valid && stream_ready) last_word <= stream_data;
	end
endmodule : lars_sink
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for the readout sequencer.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic clock, rst, serial_mode, stall, last_section_scan_done;
	logic stream_valid, stream_ready, overrun;
	logic [4:0] scan_start, scan_done, pixel_out_oe, scan_active;
	logic [39:0] pixel_level, pixel_out;
	logic [639:0] integ_reset;
	logic [17:0] stream_data, last_word;
	int errors = 0, n_compared = 0, cyc = 0, n;
	logic [7:0] lv [5] = '{8'h00, 8'hFF, 8'h5A, 8'hA5, 8'h01};
	lars_seq dut (.*);
	lars_sink sink (.*);
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	task automatic chk(string nm, logic [17:0] e, logic [17:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : tally_and_finish
	// The start bit is raised one edge before the edge that captures it.
	task automatic scan(int s);
		@(posedge clock);
		scan_start <= 5'h01 << s;
		@(posedge clock);
		scan_start <= 5'h00;
		@(posedge clock);
		#1 chk("oe", 18'(5'h01 << s), 18'(pixel_out_oe));
		chk("pix", 18'(lv[s]), 18'(pixel_out[s*8+:8]));
		repeat (126) @(posedge clock);
		#1 chk("early", 18'h00000, 18'(scan_done));
		@(posedge clock);
		#1 chk("done", 18'(5'h01 << s), 18'(scan_done));
	endtask : scan
	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			tally_and_finish();
		end
	end
	initial begin
		rst = 1'b1;
		serial_mode = 1'b0;
		stall = 1'b0;
		scan_start = 5'h00;
		pixel_level = {lv[4], lv[3], lv[2], lv[1], lv[0]};
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		#1 chk("rst", 18'h00000, 18'({scan_done, pixel_out_oe, overrun}));
		for (int i = 0; i < 5; i++) scan(i);
		repeat (4) @(posedge clock);
		#1 chk("tail", 18'({7'h7F, lv[4]}), 18'(last_word[14:0]));
		chk("ovr0", 18'h00000, 18'(overrun));
		serial_mode <= 1'b1;
		scan(0);
		n = 0;
		while (last_section_scan_done !== 1'b1 && n < 600) begin
			@(posedge clock);
			#1 n++;
		end
		chk("chain", 18'd516, 18'(n));
		serial_mode <= 1'b0;
		stall <= 1'b1;
		scan(0);
		chk("ovr1", 18'h00001, 18'(overrun));
		stall <= 1'b0;
		repeat (20) @(posedge clock);
		#1 chk("empty", 18'h00000, 18'(stream_valid));
		rst <= 1'b1;
		@(posedge clock);
		rst <= 1'b0;
		#1 chk("rst2", 18'h00000, 18'(overrun));
		// Two sections started together in parallel mode end together.
		scan_start <= 5'h05;
		@(posedge clock);
		scan_start <= 5'h00;
		repeat (128) @(posedge clock);
		#1 chk("par", 18'h00005, 18'(scan_done));
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
